// ---- src/clsc_core_ctrl.sv ----
// Lockup, sleep entry and wakeup control for the processor core
// What this block does
// - Hard fault in NMI/hard fault handler locks up
// - No instruction execution while locked up
// - Leave lockup by reset, NMI, debug halt
// - Lockup from NMI handler ignores later NMI
// - Normal sleep stops only processor clock
// - Deep sleep also stops system clocks
// - Deep sleep select chooses sleep kind
// - Wait-interrupt sleeps unless wakeup already true
// - Wait-event with event clear sleeps
// - Wait-event with event set clears, continues
// - Event register not software accessible
// - External or remote send-event sets event
// - Sleep on handler return after handler completes
// - Wait-interrupt sleep wakes on entry-capable exception
// - Masked interrupt wakes wait-interrupt sleep unless fault mask set; handler waits for unmask
// - Wait-event sleep wakes on exception or event
// - Pending-sets-event makes new pends wake
// - External event wakes or sets event register
// - Only reset and NMI preempt hard fault
`default_nettype none
`include "clsc_map.svh"
module clsc_core_ctrl
  import clsc_pkg::*;
#(
  parameter int SYNC_STAGES = `CLSC_SYNC_STAGES
)
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic waitInterruptInstr,
  input  wire logic waitEventInstr,
  input  wire logic handlerReturn,
  input  wire logic sleepOnHandlerReturn,
  input  wire logic deepSleepSelect,
  input  wire logic pendingSetsEvent,
  input  wire logic interruptMaskBit,
  input  wire logic faultMaskBit,
  input  wire logic excEntryReady,
  input  wire logic maskedIrqReady,
  input  wire logic newPending,
  input  wire logic externalEventAsync,
  input  wire logic remoteSendEvent,
  input  wire logic hardFault,
  input  wire logic inNmiHandler,
  input  wire logic inHardFaultHandler,
  input  wire logic nmiRequest,
  input  wire logic debugHalt,
  input  wire logic debugResume,
  output logic      execEnable,
  output logic      procClkEnable,
  output logic      sysClkEnable,
  output logic      deepSleepActive,
  output logic      sleepActive,
  output logic      lockupActive,
  output logic      wakeHoldHandler,
  output logic      nmiTakenFromLockup
);

  clsc_state_type            state_r;
  clsc_state_type            state_nxt;
  logic                      eventReg_r;
  logic                      eventReg_nxt;
  logic                      lockFromNmi_r;
  logic                      lockFromNmi_nxt;
  logic                      deep_r;
  logic                      deep_nxt;
  logic                      holdHandler_r;
  logic                      holdHandler_nxt;
  logic                      nmiExit_r;
  logic                      nmiExit_nxt;
  logic [SYNC_STAGES-1:0]    extSync_r;
  logic [SYNC_STAGES-1:0]    extSync_nxt;
  logic                      extEvent;
  logic                      anyEvent;
  logic                      wfiWake;
  logic                      maskedWake;

  // Only the last stage is read; the first may be metastable
  assign extEvent = extSync_r[SYNC_STAGES-1];

  // Synchroniser group kept apart so its stages never see other logic
  always_comb
  begin
    extSync_nxt = {extSync_r[SYNC_STAGES-2:0], externalEventAsync};
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      extSync_r <= '0;
    end
    else
    begin
      extSync_r <= extSync_nxt;
    end
  end

  // Event sources, including new pends when enabled
  assign anyEvent = extEvent | remoteSendEvent
                  | (pendingSetsEvent & newPending);

  // Masked interrupt wake only when fault mask is clear
  assign maskedWake = interruptMaskBit & ~faultMaskBit & maskedIrqReady;
  assign wfiWake    = excEntryReady | maskedWake;

  always_comb
  begin
    state_nxt       = state_r;
    eventReg_nxt    = eventReg_r;
    lockFromNmi_nxt = lockFromNmi_r;
    deep_nxt        = deep_r;
    holdHandler_nxt = holdHandler_r & interruptMaskBit;
    nmiExit_nxt     = 1'b0;
    // Any event sets the register; a set beats the wait-event clear in run, but the clear on wakeup from wait-event sleep wins
    if (anyEvent)
    begin
      eventReg_nxt = 1'b1;
    end
    case (state_r)
      CLSC_RUN:
      begin
        // Hard fault is only preempted by reset and NMI, so a fault here locks up
        if (hardFault && (inNmiHandler || inHardFaultHandler))
        begin
          state_nxt       = CLSC_LOCKUP;
          lockFromNmi_nxt = inNmiHandler;
        end
        else if (debugHalt)
        begin
          state_nxt = CLSC_HALTED;
        end
        else if (waitInterruptInstr ||
                 (handlerReturn && sleepOnHandlerReturn))
        begin
          if (!wfiWake)
          begin
            state_nxt = CLSC_SLEEP_WFI;
            deep_nxt  = deepSleepSelect;
          end
        end
        else if (waitEventInstr)
        begin
          if (eventReg_r)
          begin
            eventReg_nxt = anyEvent;
          end
          else if (!anyEvent && !excEntryReady)
          begin
            state_nxt = CLSC_SLEEP_WFE;
            deep_nxt  = deepSleepSelect;
          end
        end
      end
      CLSC_SLEEP_WFI:
      begin
        if (debugHalt)
        begin
          state_nxt = CLSC_HALTED;
        end
        else if (wfiWake)
        begin
          state_nxt       = CLSC_RUN;
          holdHandler_nxt = maskedWake & ~excEntryReady;
        end
      end
      CLSC_SLEEP_WFE:
      begin
        if (debugHalt)
        begin
          state_nxt = CLSC_HALTED;
        end
        else if (excEntryReady || anyEvent)
        begin
          state_nxt = CLSC_RUN;
          // Event that woke the core is consumed by this wait
          eventReg_nxt = 1'b0;
        end
      end
      CLSC_LOCKUP:
      begin
        // Only NMI or a debug halt release; reset is handled below
        if (debugHalt)
        begin
          state_nxt = CLSC_HALTED;
        end
        else if (nmiRequest && !lockFromNmi_r)
        begin
          state_nxt   = CLSC_RUN;
          nmiExit_nxt = 1'b1;
        end
      end
      CLSC_HALTED:
      begin
        if (debugResume)
        begin
          state_nxt = CLSC_RUN;
        end
      end
      default:
      begin
        state_nxt = CLSC_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_r       <= CLSC_RUN;
      eventReg_r    <= `CLSC_EVT_RESET;
      lockFromNmi_r <= 1'b0;
      deep_r        <= 1'b0;
      holdHandler_r <= 1'b0;
      nmiExit_r     <= 1'b0;
    end
    else
    begin
      state_r       <= state_nxt;
      eventReg_r    <= eventReg_nxt;
      lockFromNmi_r <= lockFromNmi_nxt;
      deep_r        <= deep_nxt;
      holdHandler_r <= holdHandler_nxt;
      nmiExit_r     <= nmiExit_nxt;
    end
  end

  // Sleep kinds gate clocks; normal sleep leaves system clocks alone
  assign sleepActive     = (state_r == CLSC_SLEEP_WFI) ||
                           (state_r == CLSC_SLEEP_WFE);
  assign procClkEnable   = ~sleepActive;
  assign deepSleepActive = sleepActive & deep_r;
  assign sysClkEnable    = ~deepSleepActive;
  assign lockupActive    = (state_r == CLSC_LOCKUP);
  assign execEnable      = (state_r == CLSC_RUN);
  assign wakeHoldHandler = holdHandler_r;
  assign nmiTakenFromLockup = nmiExit_r;

endmodule // clsc_core_ctrl
`default_nettype wire

// ---- src/clsc_map.svh ----
// Constants for the lockup and sleep control block
`ifndef CLSC_MAP_SVH
`define CLSC_MAP_SVH

`define CLSC_SYNC_STAGES 2
`define CLSC_EVT_RESET   1'b0

`endif

// ---- src/clsc_pkg.sv ----
// Types for the lockup and sleep control block
`default_nettype none
package clsc_pkg;

  typedef enum logic [2:0] {
    CLSC_RUN,
    CLSC_SLEEP_WFI,
    CLSC_SLEEP_WFE,
    CLSC_LOCKUP,
    CLSC_HALTED
  } clsc_state_type;

endpackage : clsc_pkg
`default_nettype wire

// ---- tb/clsc_chk.sv ----
// Assertions for the lockup and sleep control block
`default_nettype none
module clsc_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic waitInterruptInstr,
  input wire logic deepSleepSelect,
  input wire logic excEntryReady,
  input wire logic maskedIrqReady,
  input wire logic hardFault,
  input wire logic inNmiHandler,
  input wire logic inHardFaultHandler,
  input wire logic nmiRequest,
  input wire logic debugHalt,
  input wire logic execEnable,
  input wire logic procClkEnable,
  input wire logic sysClkEnable,
  input wire logic deepSleepActive,
  input wire logic sleepActive,
  input wire logic lockupActive,
  input wire logic nmiTakenFromLockup
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Wait-interrupt with no wakeup cause already present
  sequence s_wfi_go;
    execEnable && waitInterruptInstr && !excEntryReady && !maskedIrqReady
    && !hardFault && !debugHalt;
  endsequence
  AST_LOCK_IN: assert property (
    execEnable && hardFault && (inNmiHandler || inHardFaultHandler)
    |=> lockupActive) else $error("lockup not entered");
  AST_LOCK_CAUSE: assert property (
    $rose(lockupActive) |-> $past(hardFault)) else $error("lockup no fault");
  AST_LOCK_EXEC: assert property (
    lockupActive |-> !execEnable) else $error("exec in lockup");
  AST_LOCK_HOLD: assert property (
    lockupActive && !nmiRequest && !debugHalt |=> lockupActive)
    else $error("lockup left");
  AST_NMI_EXIT: assert property (
    nmiTakenFromLockup |-> execEnable && $past(lockupActive))
    else $error("nmi pulse wrong");
  AST_SLEEP_CLK: assert property (
    sleepActive |-> !procClkEnable && !execEnable) else $error("sleep clk");
  AST_DEEP_CLK: assert property (
    sleepActive |-> sysClkEnable == !deepSleepActive) else $error("sys clk");
  AST_WFI_SEL: assert property (
    s_wfi_go |=> sleepActive && deepSleepActive == $past(deepSleepSelect))
    else $error("wfi entry");
  AST_EXC_WAKE: assert property (
    sleepActive && excEntryReady && !debugHalt |=> !sleepActive)
    else $error("no wake");
endmodule // clsc_chk
bind clsc_core_ctrl clsc_chk i_chk (.*);
`default_nettype wire

// ---- tb/clsc_evt_model.sv ----
// Event controller model driving the core's external event line
`default_nettype none
module clsc_evt_model (
  input  wire logic pinEvent,
  output var logic  externalEventAsync
);
  timeunit 1ns;
  timeprecision 100ps;
  initial externalEventAsync = 1'b0;
  // Off-phase and over three cycles wide, so the two flops cannot miss it
  always @(posedge pinEvent)
  begin
    #7 externalEventAsync = 1'b1;
    #80 externalEventAsync = 1'b0;
  end
endmodule // clsc_evt_model
`default_nettype wire

// ---- tb/test_clsc_core_ctrl.sv ----
// Self-checking bench for the lockup and sleep control block
`default_nettype none
module test_clsc_core_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0, rst = 1'b1, pinEvent, externalEventAsync;
  logic waitInterruptInstr, waitEventInstr, handlerReturn, debugResume;
  logic sleepOnHandlerReturn, deepSleepSelect, pendingSetsEvent, nmiRequest;
  logic interruptMaskBit, faultMaskBit, excEntryReady, maskedIrqReady;
  logic newPending, remoteSendEvent, hardFault, inNmiHandler, debugHalt;
  logic inHardFaultHandler, execEnable, procClkEnable, sysClkEnable;
  logic deepSleepActive, sleepActive, lockupActive, wakeHoldHandler;
  logic nmiTakenFromLockup;
  int   errors = 0, n_tests = 0, cyc = 0;
  clsc_core_ctrl i_dut (.*);
  clsc_evt_model i_evt (.*);
  always #12.5 core_clk = ~core_clk;
  task automatic results();
    if (errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      errors++;
      results();
    end
  end
  task automatic chk(string nm, logic e, logic g);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge core_clk) s = 1'b1;
    @(negedge core_clk) s = 1'b0;
  endtask
  task automatic do_reset();
    {waitInterruptInstr, waitEventInstr, handlerReturn, debugResume,
     sleepOnHandlerReturn, deepSleepSelect, pendingSetsEvent, nmiRequest,
     interruptMaskBit, faultMaskBit, excEntryReady, maskedIrqReady,
     newPending, remoteSendEvent, hardFault, inNmiHandler, debugHalt,
     inHardFaultHandler, pinEvent} = '0;
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
  endtask
  task automatic t_wfe();
    do_reset();
    pulse(waitEventInstr);
    chk("sleep", 1'b1, sleepActive);
    pulse(remoteSendEvent);
    chk("sleep", 1'b0, sleepActive);
    pulse(remoteSendEvent);
    pulse(waitEventInstr);
    chk("sleep", 1'b0, sleepActive);
    pulse(waitEventInstr);
    chk("sleep", 1'b1, sleepActive);
    pulse(pinEvent);
    chk("sleep", 1'b1, sleepActive);
    repeat (3) @(negedge core_clk);
    chk("sleep", 1'b0, sleepActive);
  endtask
  task automatic t_pend();
    do_reset();
    pendingSetsEvent = 1'b1;
    pulse(waitEventInstr);
    pulse(newPending);
    chk("sleep", 1'b0, sleepActive);
    pulse(pinEvent);
    repeat (5) @(negedge core_clk);
    pulse(waitEventInstr);
    chk("sleep", 1'b0, sleepActive);
  endtask
  task automatic t_wfi();
    do_reset();
    deepSleepSelect = 1'b1;
    pulse(waitInterruptInstr);
    chk("deep", 1'b1, deepSleepActive);
    chk("sysclk", 1'b0, sysClkEnable);
    chk("procclk", 1'b0, procClkEnable);
    excEntryReady = 1'b1;
    @(negedge core_clk);
    chk("sleep", 1'b0, sleepActive);
    pulse(waitInterruptInstr);
    chk("sleep", 1'b0, sleepActive);
    {deepSleepSelect, excEntryReady, sleepOnHandlerReturn} = 3'b001;
    pulse(handlerReturn);
    chk("sleep", 1'b1, sleepActive);
    chk("deep", 1'b0, deepSleepActive);
    chk("sysclk", 1'b1, sysClkEnable);
    {interruptMaskBit, maskedIrqReady} = 2'b11;
    @(negedge core_clk);
    chk("sleep", 1'b0, sleepActive);
    chk("hold", 1'b1, wakeHoldHandler);
  endtask
  task automatic t_lock();
    do_reset();
    inHardFaultHandler = 1'b1;
    pulse(hardFault);
    chk("lock", 1'b1, lockupActive);
    chk("exec", 1'b0, execEnable);
    pulse(debugResume);
    chk("lock", 1'b1, lockupActive);
    pulse(nmiRequest);
    chk("nmi", 1'b1, nmiTakenFromLockup);
    {inHardFaultHandler, inNmiHandler} = 2'b01;
    pulse(hardFault);
    pulse(nmiRequest);
    chk("lock", 1'b1, lockupActive);
    pulse(debugHalt);
    chk("lock", 1'b0, lockupActive);
    pulse(debugResume);
    pulse(hardFault);
    chk("lock", 1'b1, lockupActive);
    do_reset();
    chk("lock", 1'b0, lockupActive);
    chk("exec", 1'b1, execEnable);
  endtask
  initial
  begin
    t_wfe();
    t_pend();
    t_wfi();
    t_lock();
    results();
  end
endmodule // test_clsc_core_ctrl
`default_nettype wire
